// ===== ioc_defs.svh
// Register offsets, field positions, reset values and timing counts for the irq output stage
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH
`define IOC_OFS_IDENT 8'h50
`define IOC_OFS_CFG 8'h54
`define IOC_OFS_STS 8'h58
`define IOC_OFS_EN 8'h5C
`define IOC_CFG_HOLD_HI 31
`define IOC_CFG_HOLD_LO 24
`define IOC_CFG_RESTART 14
`define IOC_CFG_ACTIVE 13
`define IOC_CFG_MASTER 12
`define IOC_CFG_OUT_EN 8
`define IOC_CFG_POL 4
`define IOC_CFG_TYPE 0
`define IOC_STS_PWR_BIT 17
`define IOC_STS_RST 32'h00000000
`define IOC_EN_RST 32'h00000000
`define IOC_STS_MASK 32'h83BF0000
`define IOC_CLK_MHZ 200
`define IOC_TICK_US 10
`define IOC_TICK_CYC (`IOC_TICK_US * `IOC_CLK_MHZ)
`define IOC_ID_DEFAULT 16'h5A5A
`define IOC_REV_DEFAULT 16'h0001
`endif

// ===== ioc_pkg.sv
// Types shared by the irq output stage modules
package ioc_pkg;
    typedef enum logic [1:0] {
        IOC_IDLE,
        IOC_ASSERTED,
        IOC_HOLDOFF
    } ioc_state_t;
endpackage : ioc_pkg

// ===== ioc_tick_if.sv
// Carrier between the holdoff timer and the prescaler
interface ioc_tick_if;
    logic restart;
    logic tick;
    modport ctl (output restart, input tick);
    modport pre (input restart, output tick);
endinterface : ioc_tick_if

// ===== ioc_prescaler.sv
// Divides the core clock down to the 10 us holdoff tick
`include "ioc_defs.svh"
module ioc_prescaler
    import ioc_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic rst, // sync reset
    ioc_tick_if.pre tk // restart in, tick out
);
    logic [15:0] cnt_r;

    always_ff @(posedge mclk) begin
        if (rst || tk.restart) begin
            cnt_r <= 16'h0000;
            tk.tick <= 1'b0;
        end else if (cnt_r == 16'(`IOC_TICK_CYC - 1)) begin
            cnt_r <= 16'h0000;
            tk.tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tk.tick <= 1'b0;
        end
    end
endmodule : ioc_prescaler

// ===== ioc_irq_output.sv
// Interrupt output stage: config, status, enable, identity and request pin
// =====================================================================
`include "ioc_defs.svh"
module ioc_irq_output
    import ioc_pkg::*;
#(
    parameter logic [15:0] CHIP_ID = `IOC_ID_DEFAULT, // arbitrary value
    parameter logic [15:0] CHIP_REV = `IOC_REV_DEFAULT // arbitrary value
) (
    input wire logic mclk, // core clock
    input wire logic rst, // system or power-on reset
    input wire logic soft_rst, // software reset
    input wire logic reg_cs, // register access strobe
    input wire logic reg_we, // write when high
    input wire logic [7:0] reg_addr, // byte offset
    input wire logic [31:0] reg_wdata, // write data
    output logic [31:0] reg_rdata, // registered read data
    input wire logic [31:0] int_event, // source event pulses
    output logic irq_o, // request pin output level
    output logic irq_oe // request pin output enable
);
    // =================================================================
    // Registers
    logic [31:0] sts_r;
    logic [31:0] en_r;
    logic [7:0] holdoff_interval_r;
    logic out_en_r;
    logic request_pin_polarity_r;
    logic buf_push_pull_r;
    logic [7:0] hold_cnt_r;
    logic holdoff_active_r;
    logic rst_any;
    logic wr_cfg;
    logic wr_sts;
    logic wr_en;
    logic holdoff_restart;
    logic master_req;
    logic pwr_req;
    logic gen_req;
    logic pin_req_nxt;
    ioc_state_t state_r;
    ioc_tick_if tk ();

    assign rst_any = rst || soft_rst;
    assign wr_cfg = reg_cs && reg_we && (reg_addr == `IOC_OFS_CFG);
    assign wr_sts = reg_cs && reg_we && (reg_addr == `IOC_OFS_STS);
    assign wr_en = reg_cs && reg_we && (reg_addr == `IOC_OFS_EN);
    assign holdoff_restart = wr_cfg && reg_wdata[`IOC_CFG_RESTART];

    // =================================================================
    // Status and enable
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            sts_r <= `IOC_STS_RST;
        end else begin
            // Set wins over a same-cycle clear
            sts_r <= ((sts_r & ~(wr_sts ? reg_wdata : 32'h00000000)) | int_event)
                     & `IOC_STS_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_any) begin
            en_r <= `IOC_EN_RST;
        end else if (wr_en) begin
            en_r <= reg_wdata & `IOC_STS_MASK;
        end
    end

    assign master_req = |(sts_r & en_r);
    assign pwr_req = sts_r[`IOC_STS_PWR_BIT] && en_r[`IOC_STS_PWR_BIT];
    assign gen_req = |(sts_r & en_r & ~(32'h1 << `IOC_STS_PWR_BIT));

    // =================================================================
    // Configuration
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            holdoff_interval_r <= 8'h00;
            out_en_r <= 1'b0;
        end else if (wr_cfg) begin
            holdoff_interval_r <= reg_wdata[`IOC_CFG_HOLD_HI:`IOC_CFG_HOLD_LO];
            out_en_r <= reg_wdata[`IOC_CFG_OUT_EN];
        end
    end

    // Only hard reset touches pin style, so soft reset cannot glitch it
    always_ff @(posedge mclk) begin
        if (rst) begin
            request_pin_polarity_r <= 1'b0;
            buf_push_pull_r <= 1'b0;
        end else if (wr_cfg) begin
            request_pin_polarity_r <= reg_wdata[`IOC_CFG_POL];
            buf_push_pull_r <= reg_wdata[`IOC_CFG_TYPE];
        end
    end

    // =================================================================
    // Holdoff sequencing
    ioc_prescaler u_pre (
        .mclk(mclk),
        .rst(rst_any),
        .tk(tk.pre)
    );

    always_ff @(posedge mclk) begin
        if (rst_any) begin
            state_r <= IOC_IDLE;
            hold_cnt_r <= 8'h00;
            holdoff_active_r <= 1'b0;
        end else if (holdoff_interval_r == 8'h00) begin
            state_r <= gen_req ? IOC_ASSERTED : IOC_IDLE;
            hold_cnt_r <= 8'h00;
            holdoff_active_r <= 1'b0;
        end else if (holdoff_restart) begin
            state_r <= IOC_HOLDOFF;
            hold_cnt_r <= 8'h00;
            holdoff_active_r <= 1'b1;
        end else begin
            case (state_r)
                IOC_IDLE: begin
                    if (gen_req) begin
                        state_r <= IOC_ASSERTED;
                    end
                end
                IOC_ASSERTED: begin
                    if (!gen_req) begin
                        state_r <= IOC_HOLDOFF;
                        hold_cnt_r <= 8'h00;
                        holdoff_active_r <= 1'b1;
                    end
                end
                IOC_HOLDOFF: begin
                    if (tk.tick) begin
                        if (hold_cnt_r + 8'h01 >= holdoff_interval_r) begin
                            state_r <= gen_req ? IOC_ASSERTED : IOC_IDLE;
                            hold_cnt_r <= 8'h00;
                            holdoff_active_r <= 1'b0;
                        end else begin
                            hold_cnt_r <= hold_cnt_r + 8'h01;
                        end
                    end
                end
                default: begin
                    state_r <= IOC_IDLE;
                    holdoff_active_r <= 1'b0;
                end
            endcase
        end
    end

    // Restart the prescaler with each interval so its length is exact
    assign tk.restart = holdoff_restart
                        || (state_r == IOC_ASSERTED && !gen_req)
                        || (holdoff_interval_r == 8'h00);

    // =================================================================
    // Request pin
    // Pin level is registered once only, so a request shows two edges after its event
    assign pin_req_nxt = out_en_r && (pwr_req || (gen_req && !holdoff_active_r));

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_o <= 1'b0;
            irq_oe <= 1'b0;
        end else if (buf_push_pull_r) begin
            irq_oe <= 1'b1;
            irq_o <= request_pin_polarity_r ? pin_req_nxt : !pin_req_nxt;
        end else begin
            irq_oe <= pin_req_nxt;
            irq_o <= 1'b0;
        end
    end

    // =================================================================
    // Read path
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_cs && !reg_we) begin
            case (reg_addr)
                `IOC_OFS_IDENT: reg_rdata <= {CHIP_ID, CHIP_REV};
                `IOC_OFS_CFG: reg_rdata <= {holdoff_interval_r, 9'h000, 1'b0,
                                            holdoff_active_r, master_req, 3'h0, out_en_r,
                                            3'h0, request_pin_polarity_r, 3'h0,
                                            buf_push_pull_r};
                `IOC_OFS_STS: reg_rdata <= sts_r;
                `IOC_OFS_EN: reg_rdata <= en_r;
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end
endmodule : ioc_irq_output

// ===== ioc_irq_output_assertions.sv
// Port checker for the irq output stage
`include "ioc_defs.svh"
module ioc_irq_output_assertions #(
    parameter logic [15:0] CHIP_ID = `IOC_ID_DEFAULT, // arbitrary value
    parameter logic [15:0] CHIP_REV = `IOC_REV_DEFAULT // arbitrary value
) (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic soft_rst, // soft reset
    input wire logic reg_cs, // strobe
    input wire logic reg_we, // write
    input wire logic [7:0] reg_addr, // offset
    input wire logic [31:0] reg_wdata, // wdata
    input wire logic [31:0] reg_rdata, // rdata
    input wire logic [31:0] int_event, // events
    input wire logic irq_o, // pin level
    input wire logic irq_oe // pin enable
);
    logic [31:0] cfg_r;
    wire logic rd = reg_cs && !reg_we;
    // Shadow of the writable config bits; soft reset spares type and polarity
    always_ff @(posedge mclk) begin
        if (rst || soft_rst)
            cfg_r <= cfg_r & {32{~rst}} & 32'h00000011;
        else if (reg_cs && reg_we && reg_addr == 8'h54)
            cfg_r <= reg_wdata & 32'hFF000111;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_ident; rd && reg_addr == 8'h50 |=> reg_rdata == {CHIP_ID, CHIP_REV}; endproperty
    a_ident: assert property (p_ident) else $error("identity read wrong");
    property p_cfg; rd && reg_addr == 8'h54 |=> (reg_rdata & 32'hFF000111) == $past(cfg_r);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config readback wrong");
    property p_rsv; rd && reg_addr == 8'h54 |=> (reg_rdata & 32'h00FF8EEE) == 0; endproperty
    a_rsv: assert property (p_rsv) else $error("config reserved bits set");
    property p_sts; rd && reg_addr == 8'h58 |=> (reg_rdata & ~32'h83BF0000) == 0; endproperty
    a_sts: assert property (p_sts) else $error("status reserved bits set");
    property p_unmap; rd && reg_addr == 8'h60 |=> reg_rdata == 0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_od; !cfg_r[0] && !$past(cfg_r[0]) |-> !irq_o; endproperty
    a_od: assert property (p_od) else $error("open drain drove high");
    property p_pp; cfg_r[0] && $past(cfg_r[0]) |-> irq_oe; endproperty
    a_pp: assert property (p_pp) else $error("push pull not driving");
    property p_off; $stable(cfg_r) && !cfg_r[8] && !$past(soft_rst)
        |-> (cfg_r[0] ? irq_o != cfg_r[4] : !irq_oe); endproperty
    a_off: assert property (p_off) else $error("disabled pin active");
    c_cfg: cover property (reg_cs && reg_we && reg_addr == 8'h54);
    c_od: cover property (irq_oe && !irq_o && !cfg_r[0]);
    c_rise: cover property ($rose(irq_o));
endmodule : ioc_irq_output_assertions
bind ioc_irq_output ioc_irq_output_assertions #(.CHIP_ID(CHIP_ID), .CHIP_REV(CHIP_REV))
    ioc_irq_output_assertions_i (.mclk, .rst, .soft_rst, .reg_cs, .reg_we, .reg_addr,
    .reg_wdata, .reg_rdata, .int_event, .irq_o, .irq_oe);

// ===== ioc_host_model.sv
// Host interrupt input with the board pull-up on the shared line
module ioc_host_model (
    input wire logic irq_o, // pin level
    input wire logic irq_oe, // pin enable
    output logic line // resolved level
);
    // Released line floats to the pull-up, as on a wired-OR net
    assign line = irq_oe ? irq_o : 1'b1;
endmodule : ioc_host_model

// ===== test_irq_output_control.sv
// Self-checking bench for the irq output stage
`include "ioc_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_irq_output_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, soft_rst = 0, reg_cs = 0, reg_we = 0, irq_o, irq_oe, line;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, int_event = 32'h0, reg_rdata, rd_v;
    int miscompares = 0, checks = 0, n;
    always #2.5 mclk = ~mclk;
    ioc_irq_output ioc_irq_output_i (.mclk, .rst, .soft_rst, .reg_cs, .reg_we,
        .reg_addr, .reg_wdata, .reg_rdata, .int_event, .irq_o, .irq_oe);
    ioc_host_model ioc_host_model_i (.irq_o, .irq_oe, .line);
    task complete_run;
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc
    // Idle cycle after each access keeps strobe edges apart
    task acc(input logic we, input logic [7:0] a, input logic [31:0] d);
        reg_cs = 1'b1;
        reg_we = we;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_cs = 1'b0;
        rd_v = reg_rdata;
        cyc(1);
    endtask : acc
    task ev(input int b);
        int_event[b] = 1'b1;
        cyc(1);
        int_event[b] = 1'b0;
    endtask : ev
    task t_regs;
        acc(1, 8'h50, 32'hFFFFFFFF);
        acc(0, 8'h50, 0);
        `CHK("ident", {`IOC_ID_DEFAULT, `IOC_REV_DEFAULT}, rd_v)
        acc(0, 8'h54, 0);
        `CHK("cfg", 32'h0, rd_v)
        acc(0, 8'h58, 0);
        `CHK("sts", 32'h0, rd_v)
        acc(0, 8'h60, 0);
        `CHK("unmapped", 32'h0, rd_v)
    endtask : t_regs
    task t_pin;
        acc(1, 8'h5C, 32'h00100000);
        acc(1, 8'h54, 32'h00000111);
        ev(20);
        cyc(3);
        `CHK("pp high", 1'b1, line)
        acc(0, 8'h54, 0);
        `CHK("master", 32'h00001111, rd_v)
        acc(1, 8'h54, 32'h00000101);
        cyc(2);
        `CHK("pp low", 1'b0, line)
        acc(1, 8'h54, 32'h00000110);
        cyc(2);
        `CHK("od", 2'b10, {irq_oe, irq_o})
        acc(1, 8'h54, 32'h00000011);
        cyc(2);
        `CHK("off", 1'b0, line)
        acc(1, 8'h58, 32'h0);
        acc(0, 8'h58, 0);
        `CHK("kept", 32'h00100000, rd_v)
        acc(1, 8'h58, 32'h00100000);
        acc(0, 8'h54, 0);
        `CHK("cleared", 32'h00000011, rd_v)
    endtask : t_pin
    task t_hold;
        acc(1, 8'h5C, 32'h00120000);
        acc(1, 8'h54, 32'h01000111);
        ev(20);
        cyc(3);
        `CHK("first", 1'b1, line)
        acc(1, 8'h58, 32'h00100000);
        acc(0, 8'h54, 0);
        `CHK("active", 1'b1, rd_v[13])
        ev(20);
        cyc(20);
        `CHK("withheld", 1'b0, line)
        n = 0;
        while (line !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        `CHK("interval", 1'b1, n > 1960 && n < 1995)
        acc(1, 8'h58, 32'h00100000);
        ev(17);
        cyc(3);
        `CHK("power", 1'b1, line)
        acc(1, 8'h58, 32'h00020000);
        ev(20);
        cyc(5);
        `CHK("pending", 1'b0, line)
        acc(1, 8'h54, 32'h00000111);
        cyc(3);
        `CHK("released", 1'b1, line)
    endtask : t_hold
    task t_restart;
        acc(1, 8'h58, 32'h00100000);
        acc(1, 8'h54, 32'h01000111);
        acc(1, 8'h54, 32'h01004111);
        acc(0, 8'h54, 0);
        `CHK("restart", 32'h01002111, rd_v)
        ev(20);
        cyc(3);
        `CHK("restart held", 1'b0, line)
        acc(1, 8'h54, 32'h00000111);
        cyc(3);
        `CHK("restart released", 1'b1, line)
    endtask : t_restart
    task t_soft;
        soft_rst = 1'b1;
        cyc(2);
        soft_rst = 1'b0;
        acc(0, 8'h54, 0);
        `CHK("soft", 32'h00000011, rd_v)
    endtask : t_soft
    initial begin
        cyc(16);
        rst = 1'b0;
        t_regs();
        t_pin();
        t_hold();
        t_restart();
        t_soft();
        complete_run();
    end
endmodule : test_irq_output_control
